/* File: rtl/line_irq_pkg.sv */
// constants for the per-link line interrupt status bank
// assumes an apb master with 32-bit data and word-aligned registers
package line_irq_pkg;
  localparam int LINK_MAX = 4;
  localparam int JW = 7;
  localparam int CW = 16;
  localparam int ADDR_W = 12;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_RX_JITTER_CFG = 8'h27;
  localparam logic [7:0] IDX_EVENT_ENABLE_A = 8'h33;
  localparam logic [7:0] IDX_EVENT_ENABLE_B = 8'h34;
  localparam logic [7:0] IDX_EDGE_SELECT = 8'h35;
  localparam logic [7:0] IDX_LINE_STATE = 8'h36;
  localparam logic [7:0] IDX_RX_JITTER = 8'h39;
  localparam logic [7:0] IDX_FLAGS_A = 8'h3a;
  localparam logic [7:0] IDX_FLAGS_B = 8'h3b;
  localparam logic [7:0] IDX_COUNT_HIGH = 8'h3c;
  localparam logic [7:0] IDX_COUNT_LOW = 8'h3d;
  localparam logic [7:0] IDX_REF_CONTROL = 8'h3e;
  localparam logic [7:0] IDX_PENDING_C = 8'h3f;
  localparam logic [7:0] IDX_PENDING_A = 8'h40;
  localparam logic [7:0] IDX_PENDING_B = 8'h41;
  // field positions
  localparam int PEAK_SELECT_BIT = 5;
  localparam int SIGNAL_LOSS_BIT = 0;
  localparam int DRIVER_FAIL_BIT = 2;
  localparam int COUNTER_WRAP_BIT = 0;
  localparam int CODE_VIOL_BIT = 1;
  localparam int ZERO_RUN_BIT = 2;
  localparam int RX_FIFO_BIT = 4;
  localparam int TX_FIFO_BIT = 5;
  localparam int TEMPLATE_BIT = 6;
  localparam int HOLD_HIGH_BIT = 0;
  localparam int LINE_PENDING_BIT = 0;
  localparam int JITTER_CLEAR_BIT = 0;
  // writable and defined bits of each register
  localparam logic [7:0] MASK_A = 8'h05;
  localparam logic [7:0] MASK_B = 8'h77;
  localparam logic [7:0] MASK_CFG = 8'h20;
  localparam logic [7:0] MASK_REF = 8'h01;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [CW-1:0] COUNT_RESET = 16'h0000;
  localparam logic [CW-1:0] COUNT_TOP = 16'hffff;
  localparam logic [JW-1:0] JITTER_RESET = 7'h00;
endpackage

/* File: rtl/line_irq_bank.sv */
// per-link line event flags, zero-run counter, jitter readback and
// module pending summary behind an apb slave.
// assumes event pulses and states come from same-clock logic; only the
// master clock pin is sampled through a synchroniser.
// Functional notes
// - test select 0 shows live pointer distance
// - test select 1 shows peak-to-peak since read
// - writing one to jitter register clears it
// - driver fail flag on rise, or both edges
// - signal loss flag on rise, or both edges
// - flags sticky until host writes one
// - template sum overflow sets its flag
// - transmit attenuator fifo slip sets flag
// - receive attenuator fifo slip sets flag
// - excessive zero run sets its flag
// - bipolar or code violation sets flag
// - zero counter wrap sets its flag
// - zero counter readable as two bytes
// - link 0 loss of signal holds references high or clock
// - line interface bit ORs line block pendings
// - other block pending bits read live
// - hdlc pending bits in bits seven to zero
// - enabled flags alone drive interrupt pin
// - state bits show driver fail and loss
// - line interface pending in lowest bit
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module line_irq_bank
  import line_irq_pkg::*;
#(
  parameter int LINKS = line_irq_pkg::LINK_MAX
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [line_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [LINKS-1:0] driver_fail_state,
  input wire logic [LINKS-1:0] signal_loss_state,
  input wire logic [LINKS-1:0] template_overflow_event,
  input wire logic [LINKS-1:0] tx_attenuator_fifo_event,
  input wire logic [LINKS-1:0] rx_attenuator_fifo_event,
  input wire logic [LINKS-1:0] zero_run_event,
  input wire logic [LINKS-1:0] code_violation_event,
  input wire logic [line_irq_pkg::JW-1:0] rx_jitter_wr_ptr [LINKS],
  input wire logic [line_irq_pkg::JW-1:0] rx_jitter_rd_ptr [LINKS],
  input wire logic [LINKS-1:0] line_block_pending,
  input wire logic [5:0] framer_blocks_pending [LINKS],
  input wire logic [7:0] hdlc_blocks_pending [LINKS],
  input wire logic master_clock,
  output logic reference_clock_out_a,
  output logic reference_clock_out_b,
  output logic irq_n
);
  import line_irq_pkg::*;

  // refused at elaboration: the address split carries two link bits
  if (LINKS < 1 || LINKS > LINK_MAX)
  begin : g_links_check
    $error("LINKS must be 1 to 4");
  end

  function automatic logic [JW-1:0] ptr_gap(input logic [JW-1:0] w,
                                            input logic [JW-1:0] r);
    ptr_gap = w - r;
  endfunction

  function automatic logic [7:0] w1c(input logic [7:0] cur,
                                     input logic [7:0] set,
                                     input logic [7:0] clr,
                                     input logic [7:0] mask);
    // a set in the clearing cycle survives
    w1c = ((cur & ~clr) | set) & mask;
  endfunction

  // register state per link
  logic [7:0] enable_a_reg [LINKS];
  logic [7:0] enable_a_next [LINKS];
  logic [7:0] enable_b_reg [LINKS];
  logic [7:0] enable_b_next [LINKS];
  logic [7:0] edge_sel_reg [LINKS];
  logic [7:0] edge_sel_next [LINKS];
  logic [7:0] jit_cfg_reg [LINKS];
  logic [7:0] jit_cfg_next [LINKS];
  logic [7:0] ref_ctl_reg [LINKS];
  logic [7:0] ref_ctl_next [LINKS];
  logic [7:0] flags_a_reg [LINKS];
  logic [7:0] flags_a_next [LINKS];
  logic [7:0] flags_b_reg [LINKS];
  logic [7:0] flags_b_next [LINKS];
  logic [CW-1:0] count_reg [LINKS];
  logic [CW-1:0] count_next [LINKS];
  logic [JW-1:0] jit_reg [LINKS];
  logic [JW-1:0] jit_next [LINKS];
  logic [JW-1:0] jmin_reg [LINKS];
  logic [JW-1:0] jmin_next [LINKS];
  logic [JW-1:0] jmax_reg [LINKS];
  logic [JW-1:0] jmax_next [LINKS];
  logic [LINKS-1:0] df_prev_reg;
  logic [LINKS-1:0] df_prev_next;
  logic [LINKS-1:0] los_prev_reg;
  logic [LINKS-1:0] los_prev_next;
  // bus and pin state
  logic [31:0] prdata_next;
  logic pready_next;
  logic pslverr_next;
  logic irq_n_next;
  logic ref_a_next;
  logic ref_b_next;
  logic mclk_meta_reg;
  logic mclk_sync_reg;

  // address split: link in the top bits, register index below
  logic [1:0] link_sel;
  logic [7:0] reg_idx;
  logic mapped;
  logic setup;
  logic done;
  assign link_sel = paddr[ADDR_W-1:ADDR_W-2];
  assign reg_idx = paddr[ADDR_W-3:2];
  assign setup = psel && !penable;
  assign done = psel && penable && pready;

  function automatic logic idx_known(input logic [7:0] i);
    unique case (i)
      IDX_RX_JITTER_CFG, IDX_EVENT_ENABLE_A, IDX_EVENT_ENABLE_B,
      IDX_EDGE_SELECT, IDX_LINE_STATE, IDX_RX_JITTER, IDX_FLAGS_A,
      IDX_FLAGS_B, IDX_COUNT_HIGH, IDX_COUNT_LOW, IDX_REF_CONTROL,
      IDX_PENDING_C, IDX_PENDING_A, IDX_PENDING_B: idx_known = 1'b1;
      default: idx_known = 1'b0;
    endcase
  endfunction

  assign mapped = (32'(link_sel) < LINKS) && idx_known(reg_idx) &&
                  (paddr[1:0] == 2'b00);

  // line interface summary: enabled own flags plus other line blocks
  function automatic logic line_pending(input logic [7:0] fa,
                                        input logic [7:0] fb,
                                        input logic [7:0] ea,
                                        input logic [7:0] eb,
                                        input logic other);
    line_pending = |(fa & ea) || |(fb & eb) || other;
  endfunction

  // per-link next state
  always_comb
  begin
    logic wr_hit;
    logic rd_hit;
    logic [7:0] set_a;
    logic [7:0] set_b;
    logic [7:0] clr;
    logic [JW-1:0] gap;
    wr_hit = 1'b0;
    rd_hit = 1'b0;
    set_a = RESET_BYTE;
    set_b = RESET_BYTE;
    clr = RESET_BYTE;
    gap = JITTER_RESET;
    for (int l = 0; l < LINKS; l++)
    begin
      wr_hit = done && pwrite && mapped && (32'(link_sel) == l);
      rd_hit = done && !pwrite && mapped && (32'(link_sel) == l);
      clr = pwdata[7:0];
      enable_a_next[l] = enable_a_reg[l];
      enable_b_next[l] = enable_b_reg[l];
      edge_sel_next[l] = edge_sel_reg[l];
      jit_cfg_next[l] = jit_cfg_reg[l];
      ref_ctl_next[l] = ref_ctl_reg[l];
      if (wr_hit && reg_idx == IDX_EVENT_ENABLE_A)
        enable_a_next[l] = pwdata[7:0] & MASK_A;
      if (wr_hit && reg_idx == IDX_EVENT_ENABLE_B)
        enable_b_next[l] = pwdata[7:0] & MASK_B;
      if (wr_hit && reg_idx == IDX_EDGE_SELECT)
        edge_sel_next[l] = pwdata[7:0] & MASK_A;
      if (wr_hit && reg_idx == IDX_RX_JITTER_CFG)
        jit_cfg_next[l] = pwdata[7:0] & MASK_CFG;
      if (wr_hit && reg_idx == IDX_REF_CONTROL)
        ref_ctl_next[l] = pwdata[7:0] & MASK_REF;

      df_prev_next[l] = driver_fail_state[l];
      los_prev_next[l] = signal_loss_state[l];
      set_a = RESET_BYTE;
      set_a[DRIVER_FAIL_BIT] = edge_sel_reg[l][DRIVER_FAIL_BIT] ?
        (driver_fail_state[l] != df_prev_reg[l]) :
        (driver_fail_state[l] && !df_prev_reg[l]);
      set_a[SIGNAL_LOSS_BIT] = edge_sel_reg[l][SIGNAL_LOSS_BIT] ?
        (signal_loss_state[l] != los_prev_reg[l]) :
        (signal_loss_state[l] && !los_prev_reg[l]);

      count_next[l] = count_reg[l];
      if (zero_run_event[l])
        count_next[l] = count_reg[l] + 16'h0001;
      set_b = RESET_BYTE;
      set_b[TEMPLATE_BIT] = template_overflow_event[l];
      set_b[TX_FIFO_BIT] = tx_attenuator_fifo_event[l];
      set_b[RX_FIFO_BIT] = rx_attenuator_fifo_event[l];
      set_b[ZERO_RUN_BIT] = zero_run_event[l];
      set_b[CODE_VIOL_BIT] = code_violation_event[l];
      set_b[COUNTER_WRAP_BIT] = zero_run_event[l] &&
                                count_reg[l] == COUNT_TOP;

      flags_a_next[l] = w1c(flags_a_reg[l], set_a,
        (wr_hit && reg_idx == IDX_FLAGS_A) ? clr : RESET_BYTE,
        MASK_A);
      flags_b_next[l] = w1c(flags_b_reg[l], set_b,
        (wr_hit && reg_idx == IDX_FLAGS_B) ? clr : RESET_BYTE,
        MASK_B);

      // peak window restarts on every read and on every write of the jitter register
      gap = ptr_gap(rx_jitter_wr_ptr[l], rx_jitter_rd_ptr[l]);
      jmin_next[l] = (gap < jmin_reg[l]) ? gap : jmin_reg[l];
      jmax_next[l] = (gap > jmax_reg[l]) ? gap : jmax_reg[l];
      if (jit_cfg_reg[l][PEAK_SELECT_BIT])
        jit_next[l] = jmax_next[l] - jmin_next[l];
      else
        jit_next[l] = gap;
      if ((rd_hit || wr_hit) && reg_idx == IDX_RX_JITTER)
      begin
        jmin_next[l] = gap;
        jmax_next[l] = gap;
      end
      if (wr_hit && reg_idx == IDX_RX_JITTER &&
          pwdata[JITTER_CLEAR_BIT])
        jit_next[l] = JITTER_RESET;
    end
  end

  // read mux and pins
  always_comb
  begin
    logic [7:0] rd;
    logic any_irq;
    logic [1:0] l;
    rd = RESET_BYTE;
    any_irq = 1'b0;
    l = link_sel;
    for (int k = 0; k < LINKS; k++)
      any_irq = any_irq || |(flags_a_reg[k] & enable_a_reg[k]) ||
                |(flags_b_reg[k] & enable_b_reg[k]);
    if (mapped)
    begin
      unique case (reg_idx)
        IDX_RX_JITTER_CFG: rd = jit_cfg_reg[l];
        IDX_EVENT_ENABLE_A: rd = enable_a_reg[l];
        IDX_EVENT_ENABLE_B: rd = enable_b_reg[l];
        IDX_EDGE_SELECT: rd = edge_sel_reg[l];
        IDX_LINE_STATE:
        begin
          rd[DRIVER_FAIL_BIT] = df_prev_reg[l];
          rd[SIGNAL_LOSS_BIT] = los_prev_reg[l];
        end
        IDX_RX_JITTER: rd = {1'b0, jit_reg[l]};
        IDX_FLAGS_A: rd = flags_a_reg[l];
        IDX_FLAGS_B: rd = flags_b_reg[l];
        IDX_COUNT_HIGH: rd = count_reg[l][CW-1:8];
        IDX_COUNT_LOW: rd = count_reg[l][7:0];
        IDX_REF_CONTROL: rd = ref_ctl_reg[l];
        IDX_PENDING_C:
          rd[LINE_PENDING_BIT] = line_pending(flags_a_reg[l],
            flags_b_reg[l], enable_a_reg[l], enable_b_reg[l],
            line_block_pending[l]);
        IDX_PENDING_A: rd = {2'b00, framer_blocks_pending[l]};
        IDX_PENDING_B: rd = hdlc_blocks_pending[l];
        default: rd = RESET_BYTE;
      endcase
    end
    // answer is ready in the access cycle after setup
    pready_next = setup;
    pslverr_next = setup && !mapped;
    prdata_next = (setup && !pwrite) ? {24'h000000, rd} : prdata;
    irq_n_next = !any_irq;
    // references follow link 0 loss; mclk passes through a sampler
    if (signal_loss_state[0] && ref_ctl_reg[0][HOLD_HIGH_BIT])
    begin
      ref_a_next = 1'b1;
      ref_b_next = 1'b1;
    end
    else
    begin
      ref_a_next = mclk_sync_reg;
      ref_b_next = mclk_sync_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int l = 0; l < LINKS; l++)
      begin
        enable_a_reg[l] <= RESET_BYTE;
        enable_b_reg[l] <= RESET_BYTE;
        edge_sel_reg[l] <= RESET_BYTE;
        jit_cfg_reg[l] <= RESET_BYTE;
        ref_ctl_reg[l] <= RESET_BYTE;
        flags_a_reg[l] <= RESET_BYTE;
        flags_b_reg[l] <= RESET_BYTE;
        count_reg[l] <= COUNT_RESET;
        jit_reg[l] <= JITTER_RESET;
        jmin_reg[l] <= JITTER_RESET;
        jmax_reg[l] <= JITTER_RESET;
      end
      df_prev_reg <= '0;
      los_prev_reg <= '0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_n <= 1'b1;
      reference_clock_out_a <= 1'b0;
      reference_clock_out_b <= 1'b0;
      mclk_meta_reg <= 1'b0;
      mclk_sync_reg <= 1'b0;
    end
    else
    begin
      enable_a_reg <= enable_a_next;
      enable_b_reg <= enable_b_next;
      edge_sel_reg <= edge_sel_next;
      jit_cfg_reg <= jit_cfg_next;
      ref_ctl_reg <= ref_ctl_next;
      flags_a_reg <= flags_a_next;
      flags_b_reg <= flags_b_next;
      count_reg <= count_next;
      jit_reg <= jit_next;
      jmin_reg <= jmin_next;
      jmax_reg <= jmax_next;
      df_prev_reg <= df_prev_next;
      los_prev_reg <= los_prev_next;
      prdata <= prdata_next;
      pready <= pready_next;
      pslverr <= pslverr_next;
      irq_n <= irq_n_next;
      reference_clock_out_a <= ref_a_next;
      reference_clock_out_b <= ref_b_next;
      mclk_meta_reg <= master_clock;
      mclk_sync_reg <= mclk_meta_reg;
    end
  end
endmodule

/* File: tb/line_irq_bank_checker.sv */
// checker of apb answers, pending readback and reference outputs
// assumes it is bound to line_irq_bank and sees its ports only
`timescale 1ns/1ps
module line_irq_bank_checker
  import line_irq_pkg::*;
#(
  parameter int LINKS = 4
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [line_irq_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [LINKS-1:0] signal_loss_state,
  input wire logic [5:0] framer_blocks_pending [LINKS],
  input wire logic [7:0] hdlc_blocks_pending [LINKS],
  input wire logic master_clock,
  input wire logic reference_clock_out_a,
  input wire logic reference_clock_out_b
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // warm-up count keeps $past away from reset-time samples
  logic [2:0] up_reg;
  logic [2:0] up_next;
  always_comb up_next = (up_reg == 3'h7) ? up_reg : up_reg + 3'h1;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      up_reg <= 3'h0;
    else
      up_reg <= up_next;
  sequence setup_s;
    psel && !penable;
  endsequence
  sequence read_s(logic [7:0] idx);
    setup_s ##0 !pwrite && paddr == {2'b00, idx, 2'b00};
  endsequence
  AST_READY_FIRST: assert property (setup_s |=> pready)
    else $error("no ready in first access cycle");
  AST_READY_PULSE: assert property (pready |=> !pready)
    else $error("ready held past one cycle");
  AST_ERR_QUAL: assert property (pslverr |-> pready)
    else $error("error response without ready");
  AST_UPPER_ZERO: assert property (pready && !pwrite |-> !prdata[31:8])
    else $error("upper read data not zero");
  AST_MISALIGNED: assert property (setup_s ##0 paddr[1:0] != 2'b00
    |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("misaligned access not refused");
  AST_PEND_A: assert property (read_s(IDX_PENDING_A)
    |=> prdata[7:0] == {2'b00, $past(framer_blocks_pending[0])})
    else $error("framer pending readback wrong");
  AST_PEND_B: assert property (read_s(IDX_PENDING_B)
    |=> prdata[7:0] == $past(hdlc_blocks_pending[0]))
    else $error("hdlc pending readback wrong");
  AST_REF_PAIR: assert property (
    reference_clock_out_a == reference_clock_out_b)
    else $error("reference outputs differ");
  AST_REF_LIVE: assert property (
    (up_reg == 3'h7 && !signal_loss_state[0])
    ##1 !signal_loss_state[0] [*4]
    |-> reference_clock_out_a == $past(master_clock, 3))
    else $error("reference output not tracking master clock");
endmodule
bind line_irq_bank line_irq_bank_checker #(.LINKS(LINKS)) chk_u (.pclk,
  .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
  .signal_loss_state, .framer_blocks_pending, .hdlc_blocks_pending,
  .master_clock, .reference_clock_out_a, .reference_clock_out_b);

/* File: tb/line_irq_bank_tb.sv */
// self-checking bench for the line interrupt status bank
// assumes the bound checker; apb driven from rising edges only
`timescale 1ns/1ps
module line_irq_bank_tb;
  import line_irq_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, master_clock = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata;
  logic pready, pslverr, reference_clock_out_a, reference_clock_out_b, irq_n;
  logic [3:0] driver_fail_state = '0, signal_loss_state = '0;
  logic [3:0] template_overflow_event = '0, tx_attenuator_fifo_event = '0;
  logic [3:0] rx_attenuator_fifo_event = '0, zero_run_event = '0;
  logic [3:0] code_violation_event = '0, line_block_pending = '0;
  logic [JW-1:0] rx_jitter_wr_ptr [4] = '{default: '0};
  logic [JW-1:0] rx_jitter_rd_ptr [4] = '{default: '0};
  logic [5:0] framer_blocks_pending [4] = '{default: '0};
  logic [7:0] hdlc_blocks_pending [4] = '{default: '0};
  int err_count = 0, n_checks = 0;
  always #5 pclk = ~pclk;
  always @(posedge pclk) master_clock <= ~master_clock;
  line_irq_bank #(.LINKS(4)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .driver_fail_state,
    .signal_loss_state, .template_overflow_event, .tx_attenuator_fifo_event,
    .rx_attenuator_fifo_event, .zero_run_event, .code_violation_event,
    .rx_jitter_wr_ptr, .rx_jitter_rd_ptr, .line_block_pending,
    .framer_blocks_pending, .hdlc_blocks_pending, .master_clock,
    .reference_clock_out_a, .reference_clock_out_b, .irq_n);
  task automatic fail(input string m);
    err_count++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e)
      fail($sformatf("got %h expected %h", g, e));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // pins sampled mid-cycle so edge updates have landed
  task automatic pins(input logic [2:0] m, input logic [2:0] e);
    @(negedge pclk);
    chk({29'h0, {irq_n, reference_clock_out_a, reference_clock_out_b} & m},
      {29'h0, e});
    @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q, output logic e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // ready and data are read at the rising edge, before it updates them
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
      fail("no ready");
  endtask
  task automatic wr(input logic [1:0] l, input logic [7:0] i,
    input logic [7:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, {l, i, 2'b00}, {24'h0, d}, q, e);
  endtask
  task automatic rc(input logic [1:0] l, input logic [7:0] i,
    input logic [7:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, {l, i, 2'b00}, 32'h0, q, e);
    chk(q, {24'h0, x});
  endtask
  task automatic pulse(input int l, input int k);
    case (k)
      1: code_violation_event[l] <= 1'b1;
      2: zero_run_event[l] <= 1'b1;
      4: rx_attenuator_fifo_event[l] <= 1'b1;
      5: tx_attenuator_fifo_event[l] <= 1'b1;
      default: template_overflow_event[l] <= 1'b1;
    endcase
    @(posedge pclk);
    code_violation_event <= '0;
    zero_run_event <= '0;
    rx_attenuator_fifo_event <= '0;
    tx_attenuator_fifo_event <= '0;
    template_overflow_event <= '0;
  endtask
  task automatic lines(input logic v);
    signal_loss_state[0] <= v;
    driver_fail_state[0] <= v;
    tick(3);
  endtask
  task automatic ptr(input logic [6:0] w, input logic [6:0] r);
    rx_jitter_wr_ptr[0] <= w;
    rx_jitter_rd_ptr[0] <= r;
    tick(2);
  endtask
  task automatic t_reset;
    for (int i = 8'h3a; i <= 8'h41; i++)
      rc(0, 8'(i), 8'h00);
    $display("reset values done");
  endtask
  task automatic t_errors;
    logic [31:0] q;
    logic e;
    apb(1'b0, 12'h000, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    apb(1'b0, 12'h0e9, 32'h0, q, e);
    chk({q[31:1], e}, 32'h1);
    $display("refusals done");
  endtask
  task automatic t_edges;
    wr(0, IDX_EVENT_ENABLE_A, 8'h05);
    lines(1'b1);
    rc(0, IDX_FLAGS_A, 8'h05);
    rc(0, IDX_LINE_STATE, 8'h05);
    rc(0, IDX_PENDING_C, 8'h01);
    pins(3'b100, 3'b000);
    wr(0, IDX_FLAGS_A, 8'h00);
    rc(0, IDX_FLAGS_A, 8'h05);
    wr(0, IDX_FLAGS_A, 8'h01);
    rc(0, IDX_FLAGS_A, 8'h04);
    wr(0, IDX_FLAGS_A, 8'h04);
    tick(2);
    pins(3'b100, 3'b100);
    lines(1'b0);
    rc(0, IDX_FLAGS_A, 8'h00);
    wr(0, IDX_EDGE_SELECT, 8'h05);
    lines(1'b1);
    wr(0, IDX_FLAGS_A, 8'h05);
    lines(1'b0);
    rc(0, IDX_FLAGS_A, 8'h05);
    wr(0, IDX_FLAGS_A, 8'h05);
    wr(0, IDX_EDGE_SELECT, 8'h00);
    $display("edge flags done");
  endtask
  task automatic t_pulses;
    wr(1, IDX_EVENT_ENABLE_B, 8'h77);
    for (int k = 1; k < 7; k++)
    begin
      if (k == 3)
        continue;
      pulse(1, k);
      tick(2);
      rc(1, IDX_FLAGS_B, 8'h01 << k);
      rc(0, IDX_FLAGS_B, 8'h00);
      pins(3'b100, 3'b000);
      wr(1, IDX_FLAGS_B, 8'h01 << k);
    end
    tick(2);
    pins(3'b100, 3'b100);
    rc(1, IDX_COUNT_LOW, 8'h01);
    wr(1, IDX_EVENT_ENABLE_B, 8'h00);
    $display("event flags done");
  endtask
  // long hold walks the counter through its wrap in one pass
  task automatic t_count;
    zero_run_event[2] <= 1'b1;
    tick(3);
    zero_run_event[2] <= 1'b0;
    rc(2, IDX_COUNT_LOW, 8'h03);
    rc(2, IDX_COUNT_HIGH, 8'h00);
    wr(2, IDX_COUNT_LOW, 8'hff);
    zero_run_event[2] <= 1'b1;
    tick(253);
    zero_run_event[2] <= 1'b0;
    rc(2, IDX_COUNT_LOW, 8'h00);
    rc(2, IDX_COUNT_HIGH, 8'h01);
    rc(2, IDX_FLAGS_B, 8'h04);
    zero_run_event[2] <= 1'b1;
    tick(65280);
    zero_run_event[2] <= 1'b0;
    rc(2, IDX_COUNT_HIGH, 8'h00);
    rc(2, IDX_FLAGS_B, 8'h05);
    pins(3'b100, 3'b100);
    wr(2, IDX_FLAGS_B, 8'h05);
    $display("counter done");
  endtask
  task automatic t_jitter;
    logic [31:0] q;
    logic e;
    ptr(7'd10, 7'd3);
    rc(0, IDX_RX_JITTER, 8'h07);
    ptr(7'd2, 7'd120);
    rc(0, IDX_RX_JITTER, 8'h0a);
    wr(0, IDX_RX_JITTER_CFG, 8'h20);
    ptr(7'd8, 7'd0);
    apb(1'b0, {2'd0, IDX_RX_JITTER, 2'b00}, 32'h0, q, e);
    ptr(7'd5, 7'd0);
    ptr(7'd20, 7'd0);
    ptr(7'd8, 7'd0);
    rc(0, IDX_RX_JITTER, 8'h0f);
    ptr(7'd20, 7'd0);
    wr(0, IDX_RX_JITTER, 8'h01);
    tick(2);
    rc(0, IDX_RX_JITTER, 8'h00);
    wr(0, IDX_RX_JITTER_CFG, 8'h00);
    $display("jitter done");
  endtask
  task automatic t_ref;
    logic r;
    wr(0, IDX_REF_CONTROL, 8'h01);
    rc(0, IDX_REF_CONTROL, 8'h01);
    signal_loss_state[0] <= 1'b1;
    tick(6);
    pins(3'b011, 3'b011);
    pins(3'b011, 3'b011);
    // hold off during loss: outputs keep following the master clock
    wr(0, IDX_REF_CONTROL, 8'h00);
    tick(2);
    @(negedge pclk);
    r = reference_clock_out_a;
    @(negedge pclk);
    chk({31'h0, reference_clock_out_a ^ r}, 32'h1);
    @(posedge pclk);
    signal_loss_state[0] <= 1'b0;
    wr(0, IDX_FLAGS_A, 8'h05);
    $display("reference outputs done");
  endtask
  task automatic t_modules;
    framer_blocks_pending[3] <= 6'h2a;
    hdlc_blocks_pending[3] <= 8'hc5;
    line_block_pending[3] <= 1'b1;
    framer_blocks_pending[0] <= 6'h31;
    hdlc_blocks_pending[0] <= 8'h5c;
    rc(0, IDX_PENDING_A, 8'h31);
    rc(0, IDX_PENDING_B, 8'h5c);
    rc(3, IDX_PENDING_A, 8'h2a);
    rc(3, IDX_PENDING_B, 8'hc5);
    rc(3, IDX_PENDING_C, 8'h01);
    wr(3, IDX_PENDING_A, 8'h00);
    rc(3, IDX_PENDING_A, 8'h2a);
    framer_blocks_pending[3] <= 6'h15;
    hdlc_blocks_pending[3] <= 8'h3a;
    line_block_pending[3] <= 1'b0;
    rc(3, IDX_PENDING_A, 8'h15);
    rc(3, IDX_PENDING_B, 8'h3a);
    rc(3, IDX_PENDING_C, 8'h00);
    $display("module pending done");
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_errors();
    t_edges();
    t_pulses();
    t_count();
    t_jitter();
    t_ref();
    t_modules();
    final_report();
  end
  initial
  begin
    repeat (90000) @(posedge pclk);
    fail("watchdog");
    final_report();
  end
endmodule
